// >>> src/fifo_defs.svh
// constants of the dual fifo: register map, field positions, resets
// assumes inclusion by bare name from the design and the bench files
`ifndef FIFO_DEFS_SVH
`define FIFO_DEFS_SVH
`define DATA_W 18
`define DEPTH_DEFAULT 256
`define OFS_W 12
`define OFS_EMPTY_DEFAULT 12'h07f
`define OFS_FULL_DEFAULT 12'h07f
`define APB_ADDR_W 12
`define CTRL_A_ADDR 12'h000
`define STAT_A_ADDR 12'h004
`define CTRL_B_ADDR 12'h008
`define STAT_B_ADDR 12'h00c
`define CTRL_W 4
`define CTRL_RESET 4'h0
`define STAT_FLAG_LSB 16
`define FALL_THROUGH_MODE_PIPE 2'h2
`endif

// >>> src/fifo_pkg.sv
// types shared by the dual fifo design
// assumes fifo_defs.svh on the include path
package fifo_pkg;
    // bit 0 fall_through_mode, 1 synchronous programmable flags,
    // 2 double-registered empty/full, 3 daisy-chain expansion
    typedef struct packed {
        logic expand;
        logic dbl_reg;
        logic flag_sync;
        logic fall_through_mode;
    } ctrl_t;
    typedef enum logic [0:0] {
        SEL_EMPTY_OFS = 1'b0,
        SEL_FULL_OFS = 1'b1
    } ofs_sel_t;
endpackage

// >>> src/dual_fifo.sv
// two independent 18-bit fifo channels with an apb control slave
// assumes write/read clocks are pins far slower than pclk (at most pclk/4)
// How it works
// - two channels, each with its own pins; only pclk, presetn and the apb slave are shared between them
// - 18-bit words, depth a parameter from 256 up to 4096
// - each channel has an 18-bit input port and 18-bit output port
// - writes timed by the write clock and gated by active-low write enable
// - one word captured on each rising write clock while enabled
// - works with read clock tied to write clock
// - works with unrelated clocks; flags kept consistent across both
// - output enable low drives data, otherwise outputs released
// - empty/output-ready and full/input-ready flags
// - almost flags with reset defaults, asynchronous or synchronous updating
// - empty and full flags through one or two register stages
// - offset load sequenced by a small machine started by load strobe
// - half-full flag only when not daisy-chained
// - standard mode: first word needs an explicit read
// - standard mode read moves next word onto the outputs
// - fall-through: first word appears after three read clock edges
// - fall-through: first word shown without read enable
// - reset clears pointers, full/almost-full high, almost-empty/empty low
// - writes ignored while full
// - reads ignored while empty, output word held
// - with load low, write/read edges move offsets through low data bits
`include "fifo_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module fifo_channel #(
    parameter int DEPTH = `DEPTH_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire fifo_pkg::ctrl_t ctrl,
    input wire logic wclk,
    input wire logic wen_n,
    input wire logic [`DATA_W-1:0] din,
    input wire logic rclk,
    input wire logic ren_n,
    input wire logic oe_n,
    input wire logic offset_load_strobe_n,
    input wire logic first_load_select_n,
    input wire logic expansion_in_n,
    output logic [`DATA_W-1:0] dout,
    output logic dout_oe,
    output logic empty_or_output_ready_n,
    output logic full_or_input_ready_n,
    output logic prog_almost_empty_n,
    output logic prog_almost_full_n,
    output logic half_full_flag_n,
    output logic expansion_out_n,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int IW = 8 + `DATA_W;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] HALF_CNT = (AW+1)'(DEPTH / 2);
    // wide enough for level plus a full 12-bit offset at any depth up to 8192
    localparam int CW = `OFS_W + 2;

    typedef struct packed {
        logic [IW-1:0] s1;
        logic [IW-1:0] s2;
        logic wclk_p;
        logic rclk_p;
        logic ld_p;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] cnt;
        logic [`DATA_W-1:0] q;
        logic ovalid;
        logic [1:0] fcnt;
        logic [`OFS_W-1:0] ofs_e;
        logic [`OFS_W-1:0] ofs_f;
        fifo_pkg::ofs_sel_t wsel;
        fifo_pkg::ofs_sel_t rsel;
        logic [1:0] arm;
        logic tok;
        logic xo;
        logic ef1;
        logic ef2;
        logic ff1;
        logic ff2;
        logic pae_n;
        logic paf_n;
        logic hf_n;
    } state_t;

    state_t st_q;
    state_t st_d;
    logic [`DATA_W-1:0] mem [DEPTH];
    logic mem_we;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic wclk_s;
        logic rclk_s;
        logic wen_s;
        logic ren_s;
        logic ld_s;
        logic [`DATA_W-1:0] din_s;
        logic wedge;
        logic redge;
        logic wr;
        logic rd;
        logic empty;
        logic full;
        logic push;
        logic pop;
        logic e_raw;
        logic f_raw;
        wclk_s = 1'b0;
        rclk_s = 1'b0;
        wen_s = 1'b1;
        ren_s = 1'b1;
        ld_s = 1'b1;
        din_s = '0;
        st_d = st_q;
        st_d.s1 = {wclk, wen_n, rclk, ren_n, oe_n, offset_load_strobe_n,
                   first_load_select_n, expansion_in_n, din};
        st_d.s2 = st_q.s1;
        {wclk_s, wen_s, rclk_s, ren_s} = st_q.s2[IW-1 -: 4];
        ld_s = st_q.s2[`DATA_W+2];
        din_s = st_q.s2[`DATA_W-1:0];
        wedge = wclk_s & ~st_q.wclk_p;
        redge = rclk_s & ~st_q.rclk_p;
        st_d.wclk_p = wclk_s;
        st_d.rclk_p = rclk_s;
        st_d.ld_p = ld_s;
        wr = wedge & ~wen_s;
        rd = redge & ~ren_s;
        empty = (st_q.cnt == '0);
        full = (st_q.cnt == FULL_CNT);
        push = 1'b0;
        pop = 1'b0;
        mem_we = 1'b0;
        st_d.xo = 1'b0;
        // daisy-chain write token, taken from first-load once inputs settle
        if (st_q.arm != 2'h3) begin
            st_d.arm = st_q.arm + 2'h1;
            st_d.tok = ~st_q.s2[`DATA_W+1];
        end else if (~st_q.s2[`DATA_W]) begin
            st_d.tok = 1'b1;
        end
        if (~ld_s & st_q.ld_p) begin
            st_d.wsel = fifo_pkg::SEL_EMPTY_OFS;
            st_d.rsel = fifo_pkg::SEL_EMPTY_OFS;
        end
        // write side
        if (wr & ~ld_s) begin
            if (st_q.wsel == fifo_pkg::SEL_EMPTY_OFS) begin
                st_d.ofs_e = din_s[`OFS_W-1:0];
                st_d.wsel = fifo_pkg::SEL_FULL_OFS;
            end else begin
                st_d.ofs_f = din_s[`OFS_W-1:0];
                st_d.wsel = fifo_pkg::SEL_EMPTY_OFS;
            end
        end else if (wr & ~full & (st_q.tok | ~ctrl.expand)) begin
            mem_we = 1'b1;
            push = 1'b1;
            st_d.wptr = next_ptr(st_q.wptr);
            if (ctrl.expand && st_q.wptr == AW'(DEPTH - 1)) begin
                st_d.tok = 1'b0;
                st_d.xo = 1'b1;
            end
        end
        // read side
        if (rd & ~ld_s) begin
            st_d.q = {(`DATA_W-`OFS_W)'(0),
                      (st_q.rsel == fifo_pkg::SEL_EMPTY_OFS) ? st_q.ofs_e : st_q.ofs_f};
            st_d.rsel = fifo_pkg::ofs_sel_t'(~st_q.rsel);
        end else if (~ctrl.fall_through_mode) begin
            if (rd & ~empty) begin
                st_d.q = mem[st_q.rptr];
                pop = 1'b1;
            end
        end else if (~st_q.ovalid) begin
            if (empty) begin
                st_d.fcnt = 2'h0;
            end else if (redge) begin
                if (st_q.fcnt == `FALL_THROUGH_MODE_PIPE) begin
                    st_d.q = mem[st_q.rptr];
                    st_d.ovalid = 1'b1;
                    st_d.fcnt = 2'h0;
                    pop = 1'b1;
                end else begin
                    st_d.fcnt = st_q.fcnt + 2'h1;
                end
            end
        end else if (rd) begin
            if (empty) begin
                st_d.ovalid = 1'b0;
            end else begin
                st_d.q = mem[st_q.rptr];
                pop = 1'b1;
            end
        end
        if (pop) begin
            st_d.rptr = next_ptr(st_q.rptr);
        end
        if (push & ~pop) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end else if (pop & ~push) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
        // flags: fixed ones through one or two stages
        e_raw = ctrl.fall_through_mode ? ~st_d.ovalid : (st_d.cnt != '0);
        f_raw = ctrl.fall_through_mode ? (st_d.cnt == FULL_CNT) : (st_d.cnt != FULL_CNT);
        st_d.ef1 = e_raw;
        st_d.ef2 = st_q.ef1;
        st_d.ff1 = f_raw;
        st_d.ff2 = st_q.ff1;
        if (~ctrl.flag_sync | redge) begin
            st_d.pae_n = CW'(st_d.cnt) > CW'(st_q.ofs_e);
        end
        if (~ctrl.flag_sync | wedge) begin
            st_d.paf_n = (CW'(st_d.cnt) + CW'(st_q.ofs_f)) < CW'(FULL_CNT);
        end
        st_d.hf_n = ctrl.expand | (st_d.cnt <= HALF_CNT);
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.s1 <= '1;
            st_q.s2 <= '1;
            st_q.ld_p <= 1'b1;
            // match the preset synchroniser so release makes no false edge
            st_q.wclk_p <= 1'b1;
            st_q.rclk_p <= 1'b1;
            st_q.ofs_e <= `OFS_EMPTY_DEFAULT;
            st_q.ofs_f <= `OFS_FULL_DEFAULT;
            st_q.ff1 <= 1'b1;
            st_q.ff2 <= 1'b1;
            st_q.paf_n <= 1'b1;
            st_q.hf_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[st_q.wptr] <= st_q.s2[`DATA_W-1:0];
        end
    end

    assign dout = st_q.q;
    assign dout_oe = ~st_q.s2[`DATA_W+3];
    assign empty_or_output_ready_n = ctrl.dbl_reg ? st_q.ef2 : st_q.ef1;
    assign full_or_input_ready_n = ctrl.dbl_reg ? st_q.ff2 : st_q.ff1;
    assign prog_almost_empty_n = st_q.pae_n;
    assign prog_almost_full_n = st_q.paf_n;
    assign half_full_flag_n = st_q.hf_n;
    assign expansion_out_n = ~st_q.xo;
    assign level = st_q.cnt;
endmodule

////////////////////////////////////////////////////////////////////////
module dual_fifo #(
    parameter int DEPTH = `DEPTH_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] wclk,
    input wire logic [1:0] wen_n,
    input wire logic [1:0][`DATA_W-1:0] din,
    input wire logic [1:0] rclk,
    input wire logic [1:0] ren_n,
    input wire logic [1:0] oe_n,
    input wire logic [1:0] offset_load_strobe_n,
    input wire logic [1:0] first_load_select_n,
    input wire logic [1:0] expansion_in_n,
    output logic [1:0][`DATA_W-1:0] dout,
    output logic [1:0] dout_oe,
    output logic [1:0] empty_or_output_ready_n,
    output logic [1:0] full_or_input_ready_n,
    output logic [1:0] prog_almost_empty_n,
    output logic [1:0] prog_almost_full_n,
    output logic [1:0] half_full_flag_n,
    output logic [1:0] expansion_out_n
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        fifo_pkg::ctrl_t [1:0] ctrl;
        logic [31:0] rdata;
    } state_t;

    state_t st_q;
    state_t st_d;
    logic [1:0][AW:0] level;
    logic hit;

    function automatic logic [31:0] status(input logic [AW:0] lv, input logic [4:0] fl);
        status = 32'(lv) | (32'(fl) << `STAT_FLAG_LSB);
    endfunction

    for (genvar c = 0; c < 2; c++) begin : g_ch
        fifo_channel #(.DEPTH(DEPTH)) u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .ctrl(st_q.ctrl[c]),
            .wclk(wclk[c]),
            .wen_n(wen_n[c]),
            .din(din[c]),
            .rclk(rclk[c]),
            .ren_n(ren_n[c]),
            .oe_n(oe_n[c]),
            .offset_load_strobe_n(offset_load_strobe_n[c]),
            .first_load_select_n(first_load_select_n[c]),
            .expansion_in_n(expansion_in_n[c]),
            .dout(dout[c]),
            .dout_oe(dout_oe[c]),
            .empty_or_output_ready_n(empty_or_output_ready_n[c]),
            .full_or_input_ready_n(full_or_input_ready_n[c]),
            .prog_almost_empty_n(prog_almost_empty_n[c]),
            .prog_almost_full_n(prog_almost_full_n[c]),
            .half_full_flag_n(half_full_flag_n[c]),
            .expansion_out_n(expansion_out_n[c]),
            .level(level[c])
        );
    end

    always_comb begin
        st_d = st_q;
        hit = 1'b1;
        unique case (paddr)
            `CTRL_A_ADDR: st_d.rdata = 32'(st_q.ctrl[0]);
            `CTRL_B_ADDR: st_d.rdata = 32'(st_q.ctrl[1]);
            `STAT_A_ADDR: st_d.rdata = status(level[0], {half_full_flag_n[0], prog_almost_full_n[0],
                prog_almost_empty_n[0], full_or_input_ready_n[0], empty_or_output_ready_n[0]});
            `STAT_B_ADDR: st_d.rdata = status(level[1], {half_full_flag_n[1], prog_almost_full_n[1],
                prog_almost_empty_n[1], full_or_input_ready_n[1], empty_or_output_ready_n[1]});
            default: begin
                hit = 1'b0;
                st_d.rdata = 32'h0000_0000;
            end
        endcase
        if (!(psel & ~penable)) begin
            st_d.rdata = st_q.rdata;
        end
        if (psel & penable & pwrite) begin
            if (paddr == `CTRL_A_ADDR) begin
                st_d.ctrl[0] = fifo_pkg::ctrl_t'(pwdata[`CTRL_W-1:0]);
            end
            if (paddr == `CTRL_B_ADDR) begin
                st_d.ctrl[1] = fifo_pkg::ctrl_t'(pwdata[`CTRL_W-1:0]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.ctrl <= {`CTRL_RESET, `CTRL_RESET};
            st_q.rdata <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
endmodule

`default_nettype wire

// >>> tb/dual_fifo_monitor.sv
// checker on the dual fifo top ports
// assumes one pclk domain, bound into dual_fifo
`include "fifo_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module dual_fifo_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] wclk,
    input wire logic [1:0] rclk,
    input wire logic [1:0] oe_n,
    input wire logic [1:0][`DATA_W-1:0] dout,
    input wire logic [1:0] dout_oe,
    input wire logic [1:0] empty_or_output_ready_n,
    input wire logic [1:0] full_or_input_ready_n,
    input wire logic [1:0] prog_almost_empty_n,
    input wire logic [1:0] prog_almost_full_n,
    input wire logic [1:0] half_full_flag_n
);
    logic [3:0] idle_q;
    logic [9:0] flags;
    assign flags = {empty_or_output_ready_n, full_or_input_ready_n, prog_almost_empty_n, prog_almost_full_n,
        half_full_flag_n};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pclks since the last pin clock change or bus access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_q <= 4'h0;
        end else if ($changed(wclk) || $changed(rclk) || psel) begin
            idle_q <= 4'h0;
        end else if (idle_q != 4'hf) begin
            idle_q <= idle_q + 4'h1;
        end
    end
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err_phase; pslverr |-> psel && penable; endproperty
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
    property p_err_map; psel && penable |-> pslverr == (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0); endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
    property p_err_rd; psel && penable && !pwrite && pslverr |-> prdata == 32'h0; endproperty
    a_err_rd: assert property (p_err_rd) else $error("unmapped read not zero");
    property p_rst; $rose(presetn) |-> flags == 10'b0011001111 && dout_oe == 2'b00; endproperty
    a_rst: assert property (p_rst) else $error("flags wrong after reset");
    property p_oe; $stable(oe_n) [*6] |-> dout_oe == ~oe_n; endproperty
    a_oe: assert property (p_oe) else $error("dout_oe not following oe_n");
    property p_flags_quiet; idle_q > 4'h8 |-> $stable(flags); endproperty
    a_flags_quiet: assert property (p_flags_quiet) else $error("flag moved without cause");
    property p_dout_quiet; idle_q > 4'h8 |-> $stable(dout); endproperty
    a_dout_quiet: assert property (p_dout_quiet) else $error("dout moved without read");
endmodule
bind dual_fifo dual_fifo_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .wclk, .rclk, .oe_n, .dout, .dout_oe, .empty_or_output_ready_n, .full_or_input_ready_n,
    .prog_almost_empty_n, .prog_almost_full_n, .half_full_flag_n);
`default_nettype wire

// >>> tb/fifo_pin_agent.sv
// writing and reading agent for one fifo channel's pins
// assumes pclk four or more times the pin clock rate
`include "fifo_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module fifo_pin_agent (
    input wire logic pclk,
    output logic wclk,
    output logic wen_n,
    output logic [`DATA_W-1:0] din,
    output logic rclk,
    output logic ren_n
);
    initial begin
        wclk = 1'b0;
        wen_n = 1'b1;
        din = '0;
        rclk = 1'b0;
        ren_n = 1'b1;
    end
    // one pin clock cycle; w picks the write side
    task cyc(input logic w, input logic en, input logic [`DATA_W-1:0] d);
        @(posedge pclk);
        if (w) begin
            wen_n <= !en;
            din <= d;
        end else begin
            ren_n <= !en;
        end
        repeat (3) @(posedge pclk);
        if (w) begin
            wclk <= 1'b1;
        end else begin
            rclk <= 1'b1;
        end
        repeat (3) @(posedge pclk);
        wclk <= 1'b0;
        rclk <= 1'b0;
        wen_n <= 1'b1;
        ren_n <= 1'b1;
        din <= ~d;
        repeat (4) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the dual fifo
// assumes fifo_pin_agent and the bound monitor
`include "fifo_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`APB_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, ev;
    logic [1:0] oe_n = 2'b00;
    logic [1:0] offset_load_strobe_n = 2'b11;
    logic [1:0] first_load_select_n = 2'b00;
    logic [1:0] expansion_in_n = 2'b11;
    wire [1:0] wclk, wen_n, rclk, ren_n;
    wire [1:0][`DATA_W-1:0] din;
    logic [1:0][`DATA_W-1:0] dout;
    logic [1:0] dout_oe, empty_or_output_ready_n, full_or_input_ready_n, prog_almost_empty_n;
    logic [1:0] prog_almost_full_n, half_full_flag_n, expansion_out_n;
    int errors = 0;
    int tests_run = 0;
    int xo_pulses = 0;
    always #5 pclk = ~pclk;
    // one-pclk expansion pulses seen on either channel
    always @(posedge pclk) if (presetn === 1'b1 && expansion_out_n !== 2'b11) xo_pulses++;
    dual_fifo #(.DEPTH(256)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .wclk, .wen_n, .din, .rclk, .ren_n, .oe_n, .offset_load_strobe_n, .first_load_select_n,
        .expansion_in_n, .dout, .dout_oe, .empty_or_output_ready_n, .full_or_input_ready_n, .prog_almost_empty_n,
        .prog_almost_full_n, .half_full_flag_n, .expansion_out_n);
    fifo_pin_agent a0 (.pclk, .wclk(wclk[0]), .wen_n(wen_n[0]), .din(din[0]), .rclk(rclk[0]), .ren_n(ren_n[0]));
    fifo_pin_agent a1 (.pclk, .wclk(wclk[1]), .wen_n(wen_n[1]), .din(din[1]), .rclk(rclk[1]), .ren_n(ren_n[1]));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [`APB_ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            errors++;
            give_verdict();
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input int c, input logic [`DATA_W-1:0] d);
        if (c == 0) a0.cyc(1'b1, 1'b1, d);
        else a1.cyc(1'b1, 1'b1, d);
    endtask
    task rd(input int c, input logic en);
        if (c == 0) a0.cyc(1'b0, en, '0);
        else a1.cyc(1'b0, en, '0);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(full_or_input_ready_n, 2'b11);
        apb(1'b0, `STAT_A_ADDR, 32'h0);
        chk(rv, 32'h001a_0000);
        apb(1'b1, `CTRL_B_ADDR, 32'hffff_fff1);
        apb(1'b0, `CTRL_B_ADDR, 32'h0);
        chk(rv, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk({ev, rv[30:0]}, 32'h8000_0000);
        for (int i = 0; i < 3; i++) wr(0, 18'h2a500 + 18'(i));
        chk(dout[0], 32'h0);
        chk(empty_or_output_ready_n[0], 32'h1);
        for (int i = 0; i < 3; i++) begin
            rd(0, 1'b1);
            chk(dout[0], 18'h2a500 + 18'(i));
        end
        for (int i = 0; i < 256; i++) wr(0, 18'h10000 + 18'(i));
        chk(full_or_input_ready_n[0], 32'h0);
        chk(half_full_flag_n[0], 32'h0);
        chk(prog_almost_full_n[0], 32'h0);
        wr(0, 18'h3ffff);
        for (int i = 0; i < 256; i++) begin
            rd(0, 1'b1);
            chk(dout[0], 18'h10000 + 18'(i));
        end
        rd(0, 1'b1);
        chk(dout[0], 32'h100ff);
        chk(empty_or_output_ready_n[0], 32'h0);
        offset_load_strobe_n[0] <= 1'b0;
        wr(0, 18'h00005);
        wr(0, 18'h000f0);
        rd(0, 1'b1);
        chk(dout[0], 32'h5);
        rd(0, 1'b1);
        chk(dout[0], 32'hf0);
        offset_load_strobe_n[0] <= 1'b1;
        for (int i = 0; i < 5; i++) wr(0, 18'(i));
        chk(prog_almost_empty_n[0], 32'h0);
        wr(0, 18'h5);
        chk(prog_almost_empty_n[0], 32'h1);
        apb(1'b0, `STAT_A_ADDR, 32'h0);
        chk(rv, 32'h001f_0006);
        wr(1, 18'h1b00d);
        rd(1, 1'b0);
        rd(1, 1'b0);
        chk(empty_or_output_ready_n[1], 32'h1);
        rd(1, 1'b0);
        chk(dout[1], 32'h1b00d);
        chk(empty_or_output_ready_n[1], 32'h0);
        apb(1'b0, `STAT_A_ADDR, 32'h0);
        chk(rv, 32'h001f_0006);
        apb(1'b1, `CTRL_A_ADDR, 32'h6);
        for (int i = 0; i < 6; i++) begin
            rd(0, 1'b1);
            chk(dout[0], 18'(i));
        end
        chk(prog_almost_empty_n[0], 32'h0);
        chk(empty_or_output_ready_n[0], 32'h0);
        apb(1'b1, `CTRL_B_ADDR, 32'h8);
        for (int i = 0; i < 256; i++) wr(1, 18'(i));
        chk(xo_pulses, 32'h1);
        chk(half_full_flag_n[1], 32'h1);
        apb(1'b0, `STAT_B_ADDR, 32'h0);
        chk(rv, 32'h0017_00ff);
        expansion_in_n[1] <= 1'b0;
        wr(1, 18'h3ffff);
        chk(full_or_input_ready_n[1], 32'h0);
        expansion_in_n[1] <= 1'b1;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `STAT_B_ADDR, 32'h0);
        chk(rv, 32'h001a_0000);
        oe_n[1] <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(dout_oe, 32'h1);
        give_verdict();
    end
    initial begin
        repeat (100000) @(posedge pclk);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
